// ### logic/sdp_regs.sv
// Functional notes
// - Stack pointer at 0x81, resets to 0x07.
// - Stack pointer names last written stack byte.
// - Push pre-increments pointer, then writes byte.
// - Low pointer byte at 0x82, bits 7-0.
// - High pointer byte at 0x83, bits 15-8.
// - Combined pointer addresses indirect data memory.
// - Both pointer bytes reset to 0x07.
// - Direct 0x80-0xFF goes to special space.
// - Pointer registers accept byte accesses only.
`timescale 1ns/10ps
`default_nettype none
module sdp_regs
   import sdp_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              reset,
   // Core register access
   input  wire sdp_pkg::sdp_req_s req,
   output var  sdp_pkg::sdp_rsp_s rsp,
   // Stack operation
   input  wire logic              push,
   input  wire logic [7:0]        push_data,
   output var  logic              stack_we,
   output var  logic [7:0]        stack_addr,
   output var  logic [7:0]        stack_wdata,
   // Pointer outputs
   output var  logic [7:0]        stack_top_pointer,
   output var  logic [15:0]       memory_pointer_16
);
   import sdp_pkg::*;

   // Direct byte write of one address; bit and indirect accesses never match.
   function automatic logic byte_wr(input sdp_req_s r, input logic [7:0] a);
      return r.wr && r.direct && !r.bit_acc && (r.addr == a);
   endfunction

   // Direct byte read of one address, decoded the same way as a write.
   function automatic logic byte_rd(input sdp_req_s r, input logic [7:0] a);
      return r.rd && r.direct && !r.bit_acc && (r.addr == a);
   endfunction

   logic [7:0] top_q, top_d;
   logic [7:0] lo_q, lo_d;
   logic [7:0] hi_q, hi_d;
   logic       swe_q, swe_d;
   logic [7:0] sad_q, sad_d;
   logic [7:0] swd_q, swd_d;
   sdp_rsp_s   rsp_q, rsp_d;
   logic       in_space;

   // Pointer registers.
   always_comb begin
      top_d = top_q;
      lo_d  = lo_q;
      hi_d  = hi_q;
      // A push outranks a same-cycle write so the stack never loses a byte it has stored.
      if (push) begin
         top_d = top_q + SDP_ONE;
      end else if (byte_wr(req, SDP_ADDR_STACK)) begin
         top_d = req.wdata;
      end
      if (byte_wr(req, SDP_ADDR_PTR_LO)) begin
         lo_d = req.wdata;
      end
      if (byte_wr(req, SDP_ADDR_PTR_HI)) begin
         hi_d = req.wdata;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         top_q <= SDP_RST_STACK;
         lo_q  <= SDP_RST_PTR_LO;
         hi_q  <= SDP_RST_PTR_HI;
      end else begin
         top_q <= top_d;
         lo_q  <= lo_d;
         hi_q  <= hi_d;
      end
   end

   // The stack write port is registered so memory sees address and data from one edge.
   always_comb begin
      swe_d = 1'h0;
      sad_d = sad_q;
      swd_d = swd_q;
      if (push) begin
         swe_d = 1'h1;
         sad_d = top_q + SDP_ONE;
         swd_d = push_data;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         swe_q <= 1'h0;
         sad_q <= SDP_ZERO;
         swd_q <= SDP_ZERO;
      end else begin
         swe_q <= swe_d;
         sad_q <= sad_d;
         swd_q <= swd_d;
      end
   end

   // Reads answer one cycle late; a read in the cycle of a write sees the old byte.
   always_comb begin
      in_space    = req.direct && (req.addr >= SDP_SPACE_BASE);
      rsp_d.hit   = 1'h0;
      rsp_d.rdata = SDP_ZERO;
      if (req.rd && in_space && !req.bit_acc) begin
         case (req.addr)
            SDP_ADDR_STACK: begin
               rsp_d.hit   = 1'h1;
               rsp_d.rdata = top_q;
            end
            SDP_ADDR_PTR_LO: begin
               rsp_d.hit   = 1'h1;
               rsp_d.rdata = lo_q;
            end
            SDP_ADDR_PTR_HI: begin
               rsp_d.hit   = 1'h1;
               rsp_d.rdata = hi_q;
            end
            default: begin
               rsp_d.hit   = 1'h0;
               rsp_d.rdata = SDP_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   assign rsp               = rsp_q;
   assign stack_we          = swe_q;
   assign stack_addr        = sad_q;
   assign stack_wdata       = swd_q;
   assign stack_top_pointer = top_q;
   assign memory_pointer_16 = {hi_q, lo_q};

   // Assertions.
   // A byte written in one cycle and read in the very next one.
   sequence s_lo_write_read;
      byte_wr(req, SDP_ADDR_PTR_LO) ##1 byte_rd(req, SDP_ADDR_PTR_LO);
   endsequence
   sequence s_hi_write_read;
      byte_wr(req, SDP_ADDR_PTR_HI) ##1 byte_rd(req, SDP_ADDR_PTR_HI);
   endsequence

   a_push_increments: assert property (@(posedge mclk) disable iff (reset)
      push |=> (top_q == $past(top_q) + SDP_ONE))
      else $error("push did not increment stack pointer");

   a_push_writes_new: assert property (@(posedge mclk) disable iff (reset)
      push |=> (stack_we && stack_addr == top_q))
      else $error("pushed byte not at incremented pointer");

   a_push_data: assert property (@(posedge mclk) disable iff (reset)
      push |=> (stack_wdata == $past(push_data)))
      else $error("pushed data mismatch");

   a_lo_write_read: assert property (@(posedge mclk) disable iff (reset)
      (byte_wr(req, SDP_ADDR_PTR_LO)) |=> (memory_pointer_16[7:0] == $past(req.wdata)))
      else $error("low pointer byte write lost");

   a_hi_write_read: assert property (@(posedge mclk) disable iff (reset)
      (byte_wr(req, SDP_ADDR_PTR_HI)) |=> (memory_pointer_16[15:8] == $past(req.wdata)))
      else $error("high pointer byte write lost");

   a_top_write: assert property (@(posedge mclk) disable iff (reset)
      (!push && byte_wr(req, SDP_ADDR_STACK)) |=> (top_q == $past(req.wdata)))
      else $error("stack pointer write lost");

   a_bit_refused: assert property (@(posedge mclk) disable iff (reset)
      (req.rd && req.bit_acc) |=> !rsp.hit)
      else $error("bit access answered by pointer register");

   a_indirect_ignored: assert property (@(posedge mclk) disable iff (reset)
      (req.rd && !req.direct) |=> !rsp.hit)
      else $error("indirect access reached special space");

   a_read_stack: assert property (@(posedge mclk) disable iff (reset)
      byte_rd(req, SDP_ADDR_STACK) |=> (rsp.hit && rsp.rdata == $past(top_q)))
      else $error("stack pointer read wrong");

   a_no_stray_we: assert property (@(posedge mclk) disable iff (reset)
      !push |=> !stack_we)
      else $error("stack write without push");

   a_reset_values: assert property (@(posedge mclk) disable iff (reset)
      $fell(reset) |-> (top_q == SDP_RST_STACK && lo_q == SDP_RST_PTR_LO
                        && hi_q == SDP_RST_PTR_HI && !stack_we))
      else $error("pointers not at reset values after reset");

   a_push_wins: assert property (@(posedge mclk) disable iff (reset)
      (push && byte_wr(req, SDP_ADDR_STACK)) |=> (top_q == $past(top_q) + SDP_ONE))
      else $error("stack pointer write beat a push");

   a_stack_holds: assert property (@(posedge mclk) disable iff (reset)
      (!push && !byte_wr(req, SDP_ADDR_STACK)) |=> $stable(top_q))
      else $error("stack pointer moved without push or write");

   a_lo_holds: assert property (@(posedge mclk) disable iff (reset)
      !byte_wr(req, SDP_ADDR_PTR_LO) |=> $stable(lo_q))
      else $error("low pointer byte moved without write");

   a_hi_holds: assert property (@(posedge mclk) disable iff (reset)
      !byte_wr(req, SDP_ADDR_PTR_HI) |=> $stable(hi_q))
      else $error("high pointer byte moved without write");

   a_read_lo: assert property (@(posedge mclk) disable iff (reset)
      byte_rd(req, SDP_ADDR_PTR_LO) |=> (rsp.hit && rsp.rdata == $past(lo_q)))
      else $error("low pointer byte read wrong");

   a_read_hi: assert property (@(posedge mclk) disable iff (reset)
      byte_rd(req, SDP_ADDR_PTR_HI) |=> (rsp.hit && rsp.rdata == $past(hi_q)))
      else $error("high pointer byte read wrong");

   a_miss_reads_zero: assert property (@(posedge mclk) disable iff (reset)
      (req.rd && !byte_rd(req, SDP_ADDR_STACK) && !byte_rd(req, SDP_ADDR_PTR_LO)
       && !byte_rd(req, SDP_ADDR_PTR_HI)) |=> (!rsp.hit && rsp.rdata == SDP_ZERO))
      else $error("unmapped read not answered with zero");

   a_lo_quick_readback: assert property (@(posedge mclk) disable iff (reset)
      s_lo_write_read |=> (rsp.hit && rsp.rdata == $past(req.wdata, 2)))
      else $error("low pointer byte not read back next cycle");

   a_hi_quick_readback: assert property (@(posedge mclk) disable iff (reset)
      s_hi_write_read |=> (rsp.hit && rsp.rdata == $past(req.wdata, 2)))
      else $error("high pointer byte not read back next cycle");
endmodule
`default_nettype wire

// ### logic/sdp_pkg.sv
package sdp_pkg;
   localparam int          SDP_AW          = 8;
   localparam int          SDP_DW          = 8;
   localparam logic [7:0]  SDP_ADDR_STACK  = 8'h81;
   localparam logic [7:0]  SDP_ADDR_PTR_LO = 8'h82;
   localparam logic [7:0]  SDP_ADDR_PTR_HI = 8'h83;
   localparam logic [7:0]  SDP_SPACE_BASE  = 8'h80;
   localparam logic [7:0]  SDP_RST_STACK   = 8'h07;
   localparam logic [7:0]  SDP_RST_PTR_LO  = 8'h07;
   localparam logic [7:0]  SDP_RST_PTR_HI  = 8'h07;
   localparam logic [7:0]  SDP_ONE         = 8'h01;
   localparam logic [7:0]  SDP_ZERO        = 8'h00;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       bit_acc;
      logic       direct;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sdp_req_s;

   typedef struct packed {
      logic       hit;
      logic [7:0] rdata;
   } sdp_rsp_s;
endpackage

// ### tb/tb_stack_and_data_pointer_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_stack_and_data_pointer_regs;
   import sdp_pkg::*;
   logic        mclk;
   logic        reset;
   sdp_req_s    req;
   sdp_rsp_s    rsp;
   logic        push;
   logic [7:0]  push_data;
   logic        stack_we;
   logic [7:0]  stack_addr;
   logic [7:0]  stack_wdata;
   logic [7:0]  stack_top;
   logic [15:0] mp;
   int          mismatches;
   int          tests_run;
   sdp_regs i_dut (.mclk(mclk), .reset(reset), .req(req), .rsp(rsp), .push(push),
      .push_data(push_data), .stack_we(stack_we), .stack_addr(stack_addr),
      .stack_wdata(stack_wdata), .stack_top_pointer(stack_top), .memory_pointer_16(mp));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // Answers are sampled mid-cycle, where the taking edge has settled.
   task automatic acc(input logic r, w, b, d, input logic [7:0] a, wd);
      @(posedge mclk);
      req <= '{rd: r, wr: w, bit_acc: b, direct: d, addr: a, wdata: wd};
      @(posedge mclk);
      req <= '0;
      @(negedge mclk);
   endtask
   task automatic rd(input logic b, d, input logic [7:0] a, input logic h, input logic [7:0] e);
      acc(1'b1, 1'b0, b, d, a, 8'h00);
      chk("rsp.hit", {15'h0000, h}, {15'h0000, rsp.hit});
      chk("rsp.rdata", {8'h00, e}, {8'h00, rsp.rdata});
   endtask
   task automatic do_push(input logic [7:0] d, input logic [7:0] e);
      @(posedge mclk);
      push <= 1'b1;
      push_data <= d;
      @(posedge mclk);
      push <= 1'b0;
      @(negedge mclk);
      chk("stack_we", 16'h0001, {15'h0000, stack_we});
      chk("stack_addr", {8'h00, e}, {8'h00, stack_addr});
      chk("stack_wdata", {8'h00, d}, {8'h00, stack_wdata});
      chk("stack_top_pointer", {8'h00, e}, {8'h00, stack_top});
      @(negedge mclk);
      chk("stack_we", 16'h0000, {15'h0000, stack_we});
   endtask
   // Write then read of one byte in the next cycle, with no idle cycle between them.
   task automatic wr_rd(input logic [7:0] a, wd);
      @(posedge mclk);
      req <= '{rd: 1'b0, wr: 1'b1, bit_acc: 1'b0, direct: 1'b1, addr: a, wdata: wd};
      @(posedge mclk);
      req <= '{rd: 1'b1, wr: 1'b0, bit_acc: 1'b0, direct: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      req <= '0;
      @(negedge mclk);
      chk("rsp.hit", 16'h0001, {15'h0000, rsp.hit});
      chk("rsp.rdata", {8'h00, wd}, {8'h00, rsp.rdata});
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      mismatches = 0;
      tests_run = 0;
      reset = 1'b1;
      req = '0;
      push = 1'b0;
      push_data = 8'h00;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      chk("stack_top_pointer", 16'h0007, {8'h00, stack_top});
      chk("memory_pointer_16", 16'h0707, mp);
      rd(1'b0, 1'b1, SDP_ADDR_STACK, 1'b1, 8'h07);
      rd(1'b0, 1'b1, SDP_ADDR_PTR_LO, 1'b1, 8'h07);
      rd(1'b0, 1'b1, SDP_ADDR_PTR_HI, 1'b1, 8'h07);
      acc(1'b0, 1'b1, 1'b0, 1'b1, SDP_ADDR_PTR_LO, 8'h5A);
      acc(1'b0, 1'b1, 1'b0, 1'b1, SDP_ADDR_PTR_HI, 8'hC3);
      chk("memory_pointer_16", 16'hC35A, mp);
      rd(1'b0, 1'b1, SDP_ADDR_PTR_LO, 1'b1, 8'h5A);
      rd(1'b0, 1'b1, SDP_ADDR_PTR_HI, 1'b1, 8'hC3);
      // Refused writes must leave both pointer bytes untouched.
      acc(1'b0, 1'b1, 1'b1, 1'b1, SDP_ADDR_PTR_LO, 8'h11);
      acc(1'b0, 1'b1, 1'b0, 1'b0, SDP_ADDR_PTR_HI, 8'h22);
      acc(1'b0, 1'b1, 1'b0, 1'b1, 8'h84, 8'h33);
      chk("memory_pointer_16", 16'hC35A, mp);
      rd(1'b1, 1'b1, SDP_ADDR_PTR_LO, 1'b0, 8'h00);
      rd(1'b0, 1'b0, SDP_ADDR_PTR_HI, 1'b0, 8'h00);
      wr_rd(SDP_ADDR_PTR_LO, 8'hA5);
      wr_rd(SDP_ADDR_PTR_HI, 8'h3C);
      chk("memory_pointer_16", 16'h3CA5, mp);
      // Two pushes from 0xFE cross the wrap of the 8-bit pointer.
      acc(1'b0, 1'b1, 1'b0, 1'b1, SDP_ADDR_STACK, 8'hFE);
      rd(1'b0, 1'b1, SDP_ADDR_STACK, 1'b1, 8'hFE);
      do_push(8'hAA, 8'hFF);
      do_push(8'h55, 8'h00);
      rd(1'b0, 1'b1, SDP_ADDR_STACK, 1'b1, 8'h00);
      // A push and a stack pointer write in one cycle: the push wins, the write is lost.
      @(posedge mclk);
      push <= 1'b1;
      push_data <= 8'h3C;
      req <= '{rd: 1'b0, wr: 1'b1, bit_acc: 1'b0, direct: 1'b1,
               addr: SDP_ADDR_STACK, wdata: 8'h40};
      @(posedge mclk);
      push <= 1'b0;
      req <= '0;
      @(negedge mclk);
      chk("stack_top_pointer", 16'h0001, {8'h00, stack_top});
      chk("stack_addr", 16'h0001, {8'h00, stack_addr});
      chk("stack_wdata", 16'h003C, {8'h00, stack_wdata});
      // A second reset in mid-run brings every pointer back to its reset value.
      @(posedge mclk);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      chk("stack_top_pointer", 16'h0007, {8'h00, stack_top});
      chk("memory_pointer_16", 16'h0707, mp);
      rd(1'b0, 1'b1, SDP_ADDR_STACK, 1'b1, 8'h07);
      // Zero written to an unoccupied address changes nothing and reads back as zero.
      acc(1'b0, 1'b1, 1'b0, 1'b1, 8'h84, 8'h00);
      chk("memory_pointer_16", 16'h0707, mp);
      rd(1'b0, 1'b1, 8'h84, 1'b0, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
